/* rtl/pin_ctl_params.svh */
`ifndef PIN_CTL_PARAMS_SVH
`define PIN_CTL_PARAMS_SVH

// register offsets (byte addresses, 8-bit data)
`define ADDR_PORTA_DATA   8'h00
`define ADDR_PORTB_DATA   8'h01
`define ADDR_PORTC_DATA   8'h02
`define ADDR_PORTD_DATA   8'h03
`define ADDR_PORTA_DIR    8'h04
`define ADDR_PORTB_DIR    8'h05
`define ADDR_PORTC_DIR    8'h06
`define ADDR_PORTD_DIR    8'h07
`define ADDR_CTRL         8'h08
`define ADDR_STATUS       8'h09

// control register fields
`define CTRL_LEVEL_SENS   0
`define CTRL_SPI_EN       1
`define CTRL_RX_EN        2
`define CTRL_TX_EN        3
`define CTRL_WDOG_EN      4
`define CTRL_CMON_EN      5
`define CTRL_RST_VAL      8'h00

// status register fields
`define STAT_REQ_LATCH    0
`define STAT_WDOG_RST     1
`define STAT_CMON_RST     2
`define STAT_ILLEGAL      3

`define DIR_RST_VAL       8'h00
`define DATA_RST_VAL      8'h00
// port D has lines 0..5 and 7
`define PORTD_MASK        8'hBF

// timing
`define WDOG_TIMEOUT_CYC  32'd65536
`define CMON_TIMEOUT_NS   32'd5000
`define CMON_TIMEOUT_CYC  (`CMON_TIMEOUT_NS / 32'd25)
`define RST_PULSE_NS      32'd1600
`define RST_PULSE_CYC     ((`RST_PULSE_NS + 32'd24) / 32'd25)

`endif

/* rtl/pin_ctl_pkg.sv */
package pin_ctl_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic       capture_in;
        logic       compare_out;
    } timer_pins_t;

    typedef struct packed {
        logic       spi_miso_in;
        logic       spi_mosi_out;
        logic       spi_sck_out;
        logic       spi_ss_in;
        logic       serial_tx_data;
    } serial_out_t;

    typedef struct packed {
        logic       spi_miso;
        logic       spi_mosi;
        logic       spi_sck;
        logic       spi_ss;
        logic       serial_rx_data;
    } serial_in_t;

    typedef enum logic [2:0] {
        IRQ_IDLE    = 3'b001,
        IRQ_PENDING = 3'b010,
        IRQ_TAKEN   = 3'b100
    } irq_state_t;

endpackage

/* rtl/irq_edge_level.sv */
`timescale 1ns/1ps
`include "pin_ctl_params.svh"

module irq_edge_level
(
    input  wire logic clk_sys_i,
    input  wire logic reset_n_i,
    input  wire logic cpu_clk_en_i,
    input  wire logic irq_pin_n_i,
    input  wire logic level_sens_i,
    input  wire logic instr_done_i,
    input  wire logic int_mask_i,
    output logic      req_latch_o,
    output logic      irq_start_o
);
    import pin_ctl_pkg::*;

    logic       sync1_r;
    logic       sync2_r;
    logic       prev_r;
    logic       req_r;
    irq_state_t state_r;
    logic       fall;
    logic       event_in;
    logic       take;

    // two-stage synchroniser on the processor clock
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            prev_r  <= 1'b1;
        end
        else if (cpu_clk_en_i)
        begin
            sync1_r <= irq_pin_n_i;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    assign fall     = cpu_clk_en_i & prev_r & ~sync2_r;
    assign event_in = fall | (level_sens_i & ~sync2_r);
    assign take     = instr_done_i & req_r & ~int_mask_i;

    // latch; a new event wins over the clear
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            req_r <= 1'b0;
        else if (event_in)
            req_r <= 1'b1;
        else if (take)
            req_r <= 1'b0;
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            state_r <= IRQ_IDLE;
        else
        begin
            case (state_r)
                IRQ_IDLE:    state_r <= req_r ? IRQ_PENDING : IRQ_IDLE;
                IRQ_PENDING: state_r <= take ? IRQ_TAKEN : (req_r ? IRQ_PENDING : IRQ_IDLE);
                IRQ_TAKEN:   state_r <= IRQ_IDLE;
                default:     state_r <= IRQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            irq_start_o <= 1'b0;
        else
            irq_start_o <= take;
    end

    assign req_latch_o = req_r;

endmodule

/* rtl/mcu_pin_and_irq_control.sv */
`timescale 1ns/1ps
`include "pin_ctl_params.svh"

module mcu_pin_and_irq_control
(
    input  wire logic                     clk_sys_i,
    input  wire logic                     reset_n_i,
    input  wire pin_ctl_pkg::reg_req_t    bus_req_i,
    output logic [7:0]                    bus_rdata_o,
    input  wire logic                     osc_in_pin_i,
    input  wire logic                     irq_pin_n_i,
    input  wire logic                     reset_pin_n_i,
    output logic                          reset_pin_n_o,
    output logic                          reset_pin_oe_o,
    output logic                          sys_reset_n_o,
    output logic                          cpu_clk_en_o,
    input  wire logic                     instr_done_i,
    input  wire logic                     int_mask_i,
    input  wire logic                     illegal_opcode_i,
    input  wire logic                     wdog_service_i,
    output logic                          irq_start_o,
    output logic                          nmi_req_o,
    input  wire logic [7:0]               port_a_lines_i,
    output logic [7:0]                    port_a_lines_o,
    output logic [7:0]                    port_a_lines_oe_o,
    input  wire logic [7:0]               port_b_lines_i,
    output logic [7:0]                    port_b_lines_o,
    output logic [7:0]                    port_b_lines_oe_o,
    input  wire logic [7:0]               port_c_lines_i,
    output logic [7:0]                    port_c_lines_o,
    output logic [7:0]                    port_c_lines_oe_o,
    input  wire logic [7:0]               port_d_lines_i,
    output logic [7:0]                    port_d_lines_o,
    output logic [7:0]                    port_d_lines_oe_o,
    input  wire pin_ctl_pkg::serial_out_t serial_drive_i,
    output pin_ctl_pkg::serial_in_t       serial_sense_o,
    output logic                          spi_en_o,
    output logic                          rx_en_o,
    output logic                          tx_en_o,
    input  wire pin_ctl_pkg::timer_pins_t timer_drive_i,
    output pin_ctl_pkg::timer_pins_t      timer_sense_o,
    input  wire logic                     capture_in_pin_i,
    output logic                          compare_out_pin_o
);
    import pin_ctl_pkg::*;

    logic [7:0]  data_r [0:3];
    logic [7:0]  dir_r  [0:3];
    logic [7:0]  ctrl_r;
    logic        div_r;
    logic        req_latch;
    logic        wdog_rst_r;
    logic        cmon_rst_r;
    logic        illegal_r;
    logic [31:0] wdog_cnt_r;
    logic [31:0] cmon_cnt_r;
    logic [31:0] rst_cnt_r;
    logic        osc_s1_r;
    logic        osc_s2_r;
    logic        osc_prev_r;
    logic        rst_s1_r;
    logic        rst_s2_r;
    logic        fail;
    logic        ext_rst;
    logic        soft_rst;
    logic [7:0]  rdata_nxt;
    logic [7:0]  pd_oe;
    logic [7:0]  pd_out;
    integer      i;

    function automatic logic is_port_reg(input logic [7:0] a);
        is_port_reg = (a[7:3] == 5'h00);
    endfunction

    // combined startup: external pin low, or internal failure pulse
    assign ext_rst  = ~rst_s2_r;
    assign soft_rst = ext_rst | (rst_cnt_r != 32'h0);
    assign sys_reset_n_o = ~soft_rst;

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= 1'b1;
        end
        else
        begin
            rst_s1_r <= reset_pin_n_i;
            rst_s2_r <= rst_s1_r;
        end
    end

    // processor clock enable, oscillator / 2
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            div_r <= 1'b0;
        else
            div_r <= ~div_r;
    end
    assign cpu_clk_en_o = div_r;

    irq_edge_level u_irq
    (
        .clk_sys_i    (clk_sys_i),
        .reset_n_i    (reset_n_i),
        .cpu_clk_en_i (div_r),
        .irq_pin_n_i  (irq_pin_n_i),
        .level_sens_i (ctrl_r[`CTRL_LEVEL_SENS]),
        .instr_done_i (instr_done_i & ~soft_rst),
        .int_mask_i   (int_mask_i),
        .req_latch_o  (req_latch),
        .irq_start_o  (irq_start_o)
    );

    // watchdog: expires unless serviced
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            wdog_cnt_r <= 32'h0;
        else if (soft_rst || wdog_service_i || !ctrl_r[`CTRL_WDOG_EN])
            wdog_cnt_r <= 32'h0;
        else if (wdog_cnt_r != `WDOG_TIMEOUT_CYC)
            wdog_cnt_r <= wdog_cnt_r + 32'h1;
    end

    // clock monitor: oscillator edges seen as an ordinary input
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            osc_s1_r   <= 1'b0;
            osc_s2_r   <= 1'b0;
            osc_prev_r <= 1'b0;
        end
        else
        begin
            osc_s1_r   <= osc_in_pin_i;
            osc_s2_r   <= osc_s1_r;
            osc_prev_r <= osc_s2_r;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            cmon_cnt_r <= 32'h0;
        else if (soft_rst || !ctrl_r[`CTRL_CMON_EN] || (osc_s2_r != osc_prev_r))
            cmon_cnt_r <= 32'h0;
        else if (cmon_cnt_r != `CMON_TIMEOUT_CYC)
            cmon_cnt_r <= cmon_cnt_r + 32'h1;
    end

    assign fail = (wdog_cnt_r == `WDOG_TIMEOUT_CYC) | (cmon_cnt_r == `CMON_TIMEOUT_CYC);

    // reset pulse on the open-drain pin
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rst_cnt_r <= 32'h0;
        else if (fail && (rst_cnt_r == 32'h0))
            rst_cnt_r <= `RST_PULSE_CYC;
        else if (rst_cnt_r != 32'h0)
            rst_cnt_r <= rst_cnt_r - 32'h1;
    end
    assign reset_pin_n_o  = 1'b0;
    assign reset_pin_oe_o = (rst_cnt_r != 32'h0);

    // failure cause flags survive the pulse, cleared by reading status
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wdog_rst_r <= 1'b0;
            cmon_rst_r <= 1'b0;
        end
        else
        begin
            if (wdog_cnt_r == `WDOG_TIMEOUT_CYC)
                wdog_rst_r <= 1'b1;
            else if (bus_req_i.rd && bus_req_i.addr == `ADDR_STATUS)
                wdog_rst_r <= 1'b0;
            if (cmon_cnt_r == `CMON_TIMEOUT_CYC)
                cmon_rst_r <= 1'b1;
            else if (bus_req_i.rd && bus_req_i.addr == `ADDR_STATUS)
                cmon_rst_r <= 1'b0;
        end
    end

    // non-maskable request; a new illegal opcode wins over the clear by instr_done_i
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            illegal_r <= 1'b0;
        else if (soft_rst)
            illegal_r <= 1'b0;
        else if (illegal_opcode_i)
            illegal_r <= 1'b1;
        else if (instr_done_i)
            illegal_r <= 1'b0;
    end
    assign nmi_req_o = illegal_r;

    // port and control registers
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            for (i = 0; i < 4; i = i + 1)
            begin
                data_r[i] <= `DATA_RST_VAL;
                dir_r[i]  <= `DIR_RST_VAL;
            end
            ctrl_r <= `CTRL_RST_VAL;
        end
        else if (soft_rst)
        begin
            for (i = 0; i < 4; i = i + 1)
                dir_r[i] <= `DIR_RST_VAL;
            ctrl_r <= `CTRL_RST_VAL;
        end
        else if (bus_req_i.wr)
        begin
            if (is_port_reg(bus_req_i.addr))
            begin
                if (bus_req_i.addr[2])
                    dir_r[bus_req_i.addr[1:0]] <= bus_req_i.wdata;
                else
                    data_r[bus_req_i.addr[1:0]] <= bus_req_i.wdata;
            end
            else if (bus_req_i.addr == `ADDR_CTRL)
                ctrl_r <= {2'h0, bus_req_i.wdata[5:0]};
        end
    end

    assign spi_en_o = ctrl_r[`CTRL_SPI_EN];
    assign rx_en_o  = ctrl_r[`CTRL_RX_EN];
    assign tx_en_o  = ctrl_r[`CTRL_TX_EN];

    assign port_a_lines_o    = data_r[0];
    assign port_a_lines_oe_o = dir_r[0];
    assign port_b_lines_o    = data_r[1];
    assign port_b_lines_oe_o = dir_r[1];
    assign port_c_lines_o    = data_r[2];
    assign port_c_lines_oe_o = dir_r[2];

    // port D: serial units override general-purpose direction and data
    always_comb
    begin
        pd_oe  = dir_r[3] & `PORTD_MASK;
        pd_out = data_r[3] & `PORTD_MASK;
        if (ctrl_r[`CTRL_RX_EN])
            pd_oe[0] = 1'b0;
        if (ctrl_r[`CTRL_TX_EN])
        begin
            pd_oe[1]  = 1'b1;
            pd_out[1] = serial_drive_i.serial_tx_data;
        end
        if (ctrl_r[`CTRL_SPI_EN])
        begin
            pd_oe[2]  = serial_drive_i.spi_miso_in;
            pd_out[2] = 1'b0;
            pd_oe[3]  = 1'b1;
            pd_out[3] = serial_drive_i.spi_mosi_out;
            pd_oe[4]  = 1'b1;
            pd_out[4] = serial_drive_i.spi_sck_out;
            pd_oe[5]  = serial_drive_i.spi_ss_in;
            pd_out[5] = 1'b0;
        end
    end
    assign port_d_lines_o    = pd_out;
    assign port_d_lines_oe_o = pd_oe;

    assign serial_sense_o.serial_rx_data = ctrl_r[`CTRL_RX_EN] & port_d_lines_i[0];
    assign serial_sense_o.spi_miso       = ctrl_r[`CTRL_SPI_EN] & port_d_lines_i[2];
    assign serial_sense_o.spi_mosi       = ctrl_r[`CTRL_SPI_EN] & port_d_lines_i[3];
    assign serial_sense_o.spi_sck        = ctrl_r[`CTRL_SPI_EN] & port_d_lines_i[4];
    assign serial_sense_o.spi_ss         = ctrl_r[`CTRL_SPI_EN] & port_d_lines_i[5];

    assign timer_sense_o.capture_in  = capture_in_pin_i;
    assign timer_sense_o.compare_out = 1'b0;
    assign compare_out_pin_o         = timer_drive_i.compare_out;

    // read data one cycle after the strobe
    always_comb
    begin
        rdata_nxt = 8'h00;
        case (bus_req_i.addr)
            `ADDR_PORTA_DATA: rdata_nxt = (port_a_lines_i & ~dir_r[0]) | (data_r[0] & dir_r[0]);
            `ADDR_PORTB_DATA: rdata_nxt = (port_b_lines_i & ~dir_r[1]) | (data_r[1] & dir_r[1]);
            `ADDR_PORTC_DATA: rdata_nxt = (port_c_lines_i & ~dir_r[2]) | (data_r[2] & dir_r[2]);
            `ADDR_PORTD_DATA: rdata_nxt = ((port_d_lines_i & ~dir_r[3]) | (data_r[3] & dir_r[3])) & `PORTD_MASK;
            `ADDR_PORTA_DIR:  rdata_nxt = dir_r[0];
            `ADDR_PORTB_DIR:  rdata_nxt = dir_r[1];
            `ADDR_PORTC_DIR:  rdata_nxt = dir_r[2];
            `ADDR_PORTD_DIR:  rdata_nxt = dir_r[3] & `PORTD_MASK;
            `ADDR_CTRL:       rdata_nxt = ctrl_r;
            `ADDR_STATUS:     rdata_nxt = {4'h0, illegal_r, cmon_rst_r, wdog_rst_r, req_latch};
            default:          rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            bus_rdata_o <= 8'h00;
        else if (bus_req_i.rd)
            bus_rdata_o <= rdata_nxt;
        else
            bus_rdata_o <= 8'h00;
    end

endmodule

/* testbench/pin_ctl_props.sv */
`timescale 1ns/1ps
module pin_ctl_props
(
    input  wire logic                     clk_sys_i,
    input  wire logic                     reset_n_i,
    input  wire logic                     cpu_clk_en_o,
    input  wire logic                     instr_done_i,
    input  wire logic                     int_mask_i,
    input  wire logic                     irq_start_o,
    input  wire logic                     illegal_opcode_i,
    input  wire logic                     nmi_req_o,
    input  wire logic                     sys_reset_n_o,
    input  wire logic                     reset_pin_n_o,
    input  wire logic                     reset_pin_oe_o,
    input  wire logic [7:0]               port_a_lines_oe_o,
    input  wire logic [7:0]               port_d_lines_i,
    input  wire logic [7:0]               port_d_lines_o,
    input  wire logic [7:0]               port_d_lines_oe_o,
    input  wire pin_ctl_pkg::serial_out_t serial_drive_i,
    input  wire pin_ctl_pkg::serial_in_t  serial_sense_o,
    input  wire logic                     spi_en_o,
    input  wire logic                     rx_en_o,
    input  wire logic                     tx_en_o,
    input  wire pin_ctl_pkg::timer_pins_t timer_drive_i,
    input  wire pin_ctl_pkg::timer_pins_t timer_sense_o,
    input  wire logic                     capture_in_pin_i,
    input  wire logic                     compare_out_pin_o
);
    import pin_ctl_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    irq_cause_a: assert property (
        irq_start_o |-> $past(instr_done_i) && !$past(int_mask_i)) else $error("irq start without cause");
    clk_div_a: assert property (
        cpu_clk_en_o |=> !cpu_clk_en_o ##1 cpu_clk_en_o) else $error("cpu clock not half rate");
    cmp_pin_a: assert property (
        compare_out_pin_o == timer_drive_i.compare_out) else $error("compare pin mismatch");
    cap_pin_a: assert property (
        timer_sense_o.capture_in == capture_in_pin_i) else $error("capture input mismatch");
    spi_map_a: assert property (
        spi_en_o |-> port_d_lines_oe_o[4:3] == 2'b11 && port_d_lines_o[3] == serial_drive_i.spi_mosi_out
            && port_d_lines_o[4] == serial_drive_i.spi_sck_out && serial_sense_o.spi_miso == port_d_lines_i[2])
        else $error("spi lines not routed");
    rx_map_a: assert property (
        rx_en_o |-> serial_sense_o.serial_rx_data == port_d_lines_i[0]) else $error("rx line not routed");
    tx_map_a: assert property (
        tx_en_o |-> port_d_lines_oe_o[1] && port_d_lines_o[1] == serial_drive_i.serial_tx_data)
        else $error("tx line not routed");
    nmi_set_a: assert property (
        illegal_opcode_i && sys_reset_n_o |=> nmi_req_o) else $error("nmi not raised");
    rst_drive_a: assert property (
        reset_pin_oe_o |-> !reset_pin_n_o && !sys_reset_n_o) else $error("reset pin drive wrong");
    rst_pulse_a: assert property (
        $rose(reset_pin_oe_o) |=> reset_pin_oe_o [*8]) else $error("reset pulse too short");
    soft_rst_a: assert property (
        !sys_reset_n_o |=> port_a_lines_oe_o == 8'h00 && port_d_lines_oe_o == 8'h00)
        else $error("lines not inputs in reset");
endmodule

bind mcu_pin_and_irq_control pin_ctl_props u_props (.clk_sys_i, .reset_n_i, .cpu_clk_en_o, .instr_done_i,
    .int_mask_i, .irq_start_o, .illegal_opcode_i, .nmi_req_o, .sys_reset_n_o, .reset_pin_n_o, .reset_pin_oe_o,
    .port_a_lines_oe_o, .port_d_lines_i, .port_d_lines_o, .port_d_lines_oe_o, .serial_drive_i, .serial_sense_o,
    .spi_en_o, .rx_en_o, .tx_en_o, .timer_drive_i, .timer_sense_o, .capture_in_pin_i, .compare_out_pin_o);

/* testbench/board_model.sv */
`timescale 1ns/1ps
module board_model
(
    input  wire logic clk_sys_i,
    input  wire logic dut_rst_n_i,
    input  wire logic dut_rst_oe_i,
    input  wire logic ext_rst_i,
    input  wire logic irq_low_i,
    input  wire logic osc_run_i,
    output logic      rst_pin_o,
    output logic      irq_pin_o,
    output logic      osc_pin_o
);
    logic osc_r = 1'b0;
    // pulled-up wired-and reset line
    assign rst_pin_o = !(ext_rst_i || (dut_rst_oe_i && !dut_rst_n_i));
    // pulled-up request line, low only while a source pulls it
    assign irq_pin_o = !irq_low_i;
    // a stopped oscillator stands still
    always @(posedge clk_sys_i)
        if (osc_run_i)
            osc_r <= ~osc_r;
    assign osc_pin_o = osc_r;
endmodule

/* testbench/mcu_pin_and_irq_control_bench.sv */
`timescale 1ns/1ps
`include "pin_ctl_params.svh"
module mcu_pin_and_irq_control_bench;
    import pin_ctl_pkg::*;
    logic        clk_sys_i, reset_n_i, instr_done, int_mask, illegal, ext_rst, irq_low, osc_run, cap_pin, wdog_svc;
    logic        rst_pin, irq_pin, osc_pin, rst_n_o, rst_oe, sys_rst_n, clk_en, irq_start, nmi;
    logic        spi_en, rx_en, tx_en, cmp_pin;
    logic [7:0]  bus_rdata_o;
    logic [7:0]  p_i[4], p_o[4], p_oe[4], p_ext[4];
    reg_req_t    bus_req_i;
    serial_out_t sdrv;
    serial_in_t  ssen;
    timer_pins_t tdrv, tsen;
    int          errors = 0, cmp_count = 0, starts = 0, n;

    mcu_pin_and_irq_control dut (.clk_sys_i, .reset_n_i, .bus_req_i, .bus_rdata_o, .osc_in_pin_i(osc_pin),
        .irq_pin_n_i(irq_pin), .reset_pin_n_i(rst_pin), .reset_pin_n_o(rst_n_o), .reset_pin_oe_o(rst_oe),
        .sys_reset_n_o(sys_rst_n), .cpu_clk_en_o(clk_en), .instr_done_i(instr_done), .int_mask_i(int_mask),
        .illegal_opcode_i(illegal), .wdog_service_i(wdog_svc), .irq_start_o(irq_start), .nmi_req_o(nmi),
        .port_a_lines_i(p_i[0]), .port_a_lines_o(p_o[0]), .port_a_lines_oe_o(p_oe[0]),
        .port_b_lines_i(p_i[1]), .port_b_lines_o(p_o[1]), .port_b_lines_oe_o(p_oe[1]),
        .port_c_lines_i(p_i[2]), .port_c_lines_o(p_o[2]), .port_c_lines_oe_o(p_oe[2]),
        .port_d_lines_i(p_i[3]), .port_d_lines_o(p_o[3]), .port_d_lines_oe_o(p_oe[3]),
        .serial_drive_i(sdrv), .serial_sense_o(ssen), .spi_en_o(spi_en), .rx_en_o(rx_en), .tx_en_o(tx_en),
        .timer_drive_i(tdrv), .timer_sense_o(tsen), .capture_in_pin_i(cap_pin), .compare_out_pin_o(cmp_pin));

    board_model bm (.clk_sys_i, .dut_rst_n_i(rst_n_o), .dut_rst_oe_i(rst_oe), .ext_rst_i(ext_rst),
        .irq_low_i(irq_low), .osc_run_i(osc_run), .rst_pin_o(rst_pin), .irq_pin_o(irq_pin), .osc_pin_o(osc_pin));

    // pin level seen by each line: own drive where enabled, board level elsewhere
    for (genvar g = 0; g < 4; g++)
    begin : pin_res
        assign p_i[g] = (p_oe[g] & p_o[g]) | (~p_oe[g] & p_ext[g]);
    end

    initial
    begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i)
        if (irq_start === 1'b1)
            starts <= starts + 1;

    task test_done;
        $display("counts: %0d errors, %0d compares", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i) bus_req_i <= {a, d, 2'b10};
        @(posedge clk_sys_i) bus_req_i <= '0;
    endtask

    task rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(posedge clk_sys_i) bus_req_i <= {a, 8'h00, 2'b01};
        @(posedge clk_sys_i) bus_req_i <= '0;
        #1 chk(nm, e, bus_rdata_o);
    endtask

    task done_p;
        @(posedge clk_sys_i) instr_done <= 1'b1;
        @(posedge clk_sys_i) instr_done <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
    endtask

    task t_ports;
        for (int k = 0; k < 3; k++)
        begin
            wr(8'h04 + k[7:0], 8'hA5 ^ k[7:0]);
            wr(k[7:0], 8'h3C);
            rchk(8'h04 + k[7:0], 8'hA5 ^ k[7:0], "dir");
            chk("oe", 8'hA5 ^ k[7:0], p_oe[k]);
            chk("out", 8'h3C, p_o[k]);
        end
        rchk(8'h20, 8'h00, "unmapped");
        wr(8'h07, 8'hFF);
        #1 chk("pd oe", 8'hBF, p_oe[3]);
        wr(8'h07, 8'h00);
    endtask

    task t_irq_edge;
        int_mask <= 1'b1;
        irq_low <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        done_p;
        chk("masked", 8'd0, starts[7:0]);
        rchk(8'h09, 8'h01, "latch");
        @(posedge clk_sys_i) int_mask <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        chk("no done", 8'd0, starts[7:0]);
        done_p;
        chk("taken", 8'd1, starts[7:0]);
        rchk(8'h09, 8'h00, "latch clr");
        done_p;
        chk("edge once", 8'd1, starts[7:0]);
        irq_low <= 1'b0;
    endtask

    task t_irq_level;
        wr(8'h08, 8'h01);
        irq_low <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        done_p;
        done_p;
        chk("level", 8'd3, starts[7:0]);
        irq_low <= 1'b0;
        repeat (8) @(posedge clk_sys_i);
        done_p;
        n = starts;
        done_p;
        chk("level off", n[7:0], starts[7:0]);
        wr(8'h08, 8'h00);
    endtask

    task t_serial;
        sdrv <= 5'b01001;
        p_ext[3] <= 8'h05;
        wr(8'h08, 8'h0E);
        #1 chk("en", 8'h07, {5'd0, spi_en, rx_en, tx_en});
        chk("pd oe", 8'h1A, p_oe[3] & 8'h1A);
        chk("pd out", 8'h0A, p_o[3] & 8'h1A);
        chk("sense", 8'h19, {3'd0, ssen});
        @(posedge clk_sys_i) sdrv <= 5'b10110;
        p_ext[3] <= 8'h00;
        @(posedge clk_sys_i);
        #1 chk("pd out", 8'h10, p_o[3] & 8'h1A);
        chk("pd slave oe", 8'h3E, p_oe[3] & 8'h3E);
        chk("sense", 8'h04, {3'd0, ssen});
        wr(8'h08, 8'h00);
        #1 chk("pd free", 8'h00, p_oe[3]);
    endtask

    task t_timer;
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk_sys_i) tdrv <= {1'b0, i[0]};
            cap_pin <= !i[0];
            @(posedge clk_sys_i);
            #1 chk("cmp pin", i[0], cmp_pin);
            chk("cap", !i[0], tsen.capture_in);
        end
    endtask

    task t_nmi;
        @(posedge clk_sys_i) illegal <= 1'b1;
        @(posedge clk_sys_i) illegal <= 1'b0;
        #1 chk("nmi", 8'd1, nmi);
        rchk(8'h09, 8'h08, "nmi stat");
        done_p;
        chk("nmi clr", 8'd0, nmi);
    endtask

    task t_cmon;
        wr(8'h08, 8'h20);
        repeat (300) @(posedge clk_sys_i);
        chk("osc ok", 8'd0, rst_oe);
        osc_run <= 1'b0;
        n = 0;
        while (rst_oe !== 1'b1 && n < 400)
        begin
            @(posedge clk_sys_i);
            #1 n++;
        end
        if (n >= 400)
        begin
            errors++;
            test_done;
        end
        chk("cmon time", 8'd1, n >= `CMON_TIMEOUT_CYC && n <= `CMON_TIMEOUT_CYC + 8);
        chk("pin low", 8'd0, rst_pin);
        osc_run <= 1'b1;
        n = 0;
        while (rst_oe === 1'b1 && n < 100)
        begin
            @(posedge clk_sys_i);
            #1 n++;
        end
        chk("pulse len", 8'(`RST_PULSE_CYC), n[7:0]);
        repeat (8) @(posedge clk_sys_i);
        rchk(8'h09, 8'h04, "cmon stat");
        rchk(8'h08, 8'h00, "ctrl");
    endtask

    task t_wdog;
        wr(8'h08, 8'h10);
        repeat (1000) @(posedge clk_sys_i);
        wdog_svc <= 1'b1;
        @(posedge clk_sys_i) wdog_svc <= 1'b0;
        n = 0;
        while (rst_oe !== 1'b1 && n < 70000)
        begin
            @(posedge clk_sys_i);
            #1 n++;
        end
        if (n >= 70000)
        begin
            errors++;
            test_done;
        end
        chk("wdog time", 8'd1, n >= `WDOG_TIMEOUT_CYC && n <= `WDOG_TIMEOUT_CYC + 8);
        repeat (80) @(posedge clk_sys_i);
        rchk(8'h09, 8'h02, "wdog stat");
    endtask

    task t_ext_rst;
        wr(8'h04, 8'hFF);
        wr(8'h07, 8'hFF);
        wr(8'h08, 8'h0E);
        ext_rst <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        #1 chk("sys rst", 8'd0, sys_rst_n);
        @(posedge clk_sys_i) ext_rst <= 1'b0;
        repeat (8) @(posedge clk_sys_i);
        rchk(8'h04, 8'h00, "dir a");
        rchk(8'h07, 8'h00, "dir d");
        rchk(8'h08, 8'h00, "ctrl");
        chk("pd oe", 8'h00, p_oe[3]);
    endtask

    initial
    begin
        bus_req_i = '0;
        {instr_done, int_mask, illegal, ext_rst, irq_low, cap_pin, wdog_svc} = '0;
        osc_run = 1'b1;
        sdrv = '0;
        tdrv = '0;
        p_ext = '{default: 8'h00};
        reset_n_i = 1'b0;
        repeat (16) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        t_ports;
        t_irq_edge;
        t_irq_level;
        t_serial;
        t_timer;
        t_nmi;
        t_cmon;
        t_wdog;
        t_ext_rst;
        test_done;
    end
endmodule
